/* bench/lil_monitor.sv */
`timescale 1ns/10ps
module lil_monitor (
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_ack_o, // acknowledge
  input wire logic [4:0] rly_req_i, // relay drives
  input wire logic selfsup_ok_i, // supervision in
  input wire logic [3:0] led_red_o, // red lamps
  input wire logic [3:0] led_green_o, // green lamps
  input wire logic relay_output_1_state_o, // relay 1
  input wire logic relay_output_2_state_o, // relay 2
  input wire logic relay_output_3_state_o, // relay 3
  input wire logic relay_output_4_state_o, // relay 4
  input wire logic relay_output_5_state_o, // relay 5
  input wire logic selfsup_o, // supervision out
  input wire logic disarmed_o, // disarmed flag
  input wire logic outs_forced_o // forced flag
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // relay states gathered so one check covers all five
  wire [4:0] rly = {relay_output_5_state_o, relay_output_4_state_o, relay_output_3_state_o,
    relay_output_2_state_o, relay_output_1_state_o};
  wire quiet = !outs_forced_o && !disarmed_o; // no override active
  // a fresh request not yet answered
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  ack_after_req_a: assert property (s_req |=> wb_ack_o) else $error("ack late");
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  colour_single_a: assert property ((led_red_o & led_green_o) == 4'h0)
    else $error("two colours lit");
  relay_follow_a: assert property (quiet && $past(quiet) |-> rly == $past(rly_req_i))
    else $error("relay not following");
  disarm_zero_a: assert property (disarmed_o && $past(disarmed_o) |-> rly == 5'h00)
    else $error("relay live while disarmed");
  selfsup_keep_a: assert property (!rst_i |=> selfsup_o == $past(selfsup_ok_i))
    else $error("supervision contact wrong");
  forced_by_write_a: assert property ($changed(outs_forced_o) |->
    $past(wb_ack_o) || $past(wb_ack_o, 2)) else $error("forced flag moved alone");
  disarm_by_write_a: assert property ($changed(disarmed_o) |->
    $past(wb_ack_o) || $past(wb_ack_o, 2)) else $error("disarm flag moved alone");
endmodule

/* bench/lil_src.sv */
`timescale 1ns/10ps
module lil_src (
  input wire logic clk_i, // clock
  output logic [31:0] sig_o, // protection signals
  output logic alarm_o, // alarm level
  output logic [4:0] rly_o, // relay drives
  output logic ss_o // supervision healthy
);
  // start quiet and healthy so nothing picks up during reset
  initial begin
    sig_o = 32'h00000000;
    alarm_o = 1'b0;
    rly_o = 5'h00;
    ss_o = 1'b1;
  end
  // sources are same-clock logic, so levels move just after an edge
  task set(input logic [31:0] s, input logic a, input logic [4:0] r, input logic h);
    @(posedge clk_i);
    sig_o <= s;
    alarm_o <= a;
    rly_o <= r;
    ss_o <= h;
  endtask
endmodule

/* bench/testbench.sv */
`timescale 1ns/10ps
`include "lil_defs.vh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module testbench;
  logic clk_i, rst_i, cyc, stb, we;
  logic [7:0] adr;
  logic [31:0] dat, rd;
  wire [31:0] wb_dat_o, sig;
  wire wb_ack_o, irq_o, alarm, ss, sso, dis, frc;
  wire [3:0] red, grn;
  wire [4:0] rly, req;
  int n_fail = 0, cmp_count = 0, nr, ng;
  localparam logic [7:0] SEL0 = `LIL_ADR_LBASE; // led 0 source select
  localparam logic [7:0] CFG0 = `LIL_ADR_LBASE + 8'h04; // led 0 config
  lil_src lil_src_inst (.clk_i(clk_i), .sig_o(sig), .alarm_o(alarm), .rly_o(req), .ss_o(ss));
  // short blink so flashing shows within a few dozen cycles
  lil_top #(.BLINK_HALF(32'd8)) lil_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .sig_i(sig), .alarm_i(alarm),
    .rly_req_i(req), .selfsup_ok_i(ss), .led_red_o(red), .led_green_o(grn),
    .relay_output_1_state_o(rly[0]), .relay_output_2_state_o(rly[1]),
    .relay_output_3_state_o(rly[2]), .relay_output_4_state_o(rly[3]),
    .relay_output_5_state_o(rly[4]), .selfsup_o(sso), .disarmed_o(dis), .outs_forced_o(frc));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // one classic cycle; holds everything until ack is sampled
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // let registers written at the ack edge settle before callers compare
    #1;
  endtask
  // lamp of led 0 after the longest two-edge path has settled
  task lamp(input string n, input logic r, input logic g);
    repeat (3) @(posedge clk_i);
    #1;
    `CHK(n, {r, g}, {red[0], grn[0]})
  endtask
  task stop_test;
    if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    stop_test;
  end
  initial begin
    {cyc, stb, we, adr, dat} = 0;
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, CFG0, 0);
    `CHK("cfg reset", `LIL_CFG_RST, rd)
    `CHK("off lamps", 4'hF, grn)
    bus(0, 8'hFC, 0);
    `CHK("unmapped", 32'h0, rd)
    bus(1, SEL0, 32'h3);
    bus(1, CFG0, 32'h1001);
    lil_src_inst.set(32'h8, 0, 0, 1);
    lamp("on colour", 1, 0);
    lil_src_inst.set(0, 0, 0, 1);
    lamp("off colour", 0, 1);
    bus(1, CFG0, 32'h1021);
    lamp("inverted low", 1, 0);
    lil_src_inst.set(32'h8, 0, 0, 1);
    lamp("inverted high", 0, 1);
    bus(1, CFG0, 32'h1040);
    lamp("empty inverted", 1, 0);
    bus(1, `LIL_ADR_ICLR, 32'hF);
    bus(1, `LIL_ADR_IEN, 32'h1);
    bus(1, CFG0, 32'h1400);
    bus(1, CFG0, 32'h1401);
    lamp("latch set", 1, 0);
    `CHK("irq raised", 1'b1, irq_o)
    bus(1, `LIL_ADR_ACK, 32'h1);
    lil_src_inst.set(0, 0, 0, 1);
    lamp("ack with cause", 1, 0);
    bus(1, `LIL_ADR_IEN, 32'h0);
    `CHK("irq masked", 1'b0, irq_o)
    bus(0, `LIL_ADR_ISTAT, 0);
    `CHK("status sticky", 1'b1, rd[0])
    bus(1, `LIL_ADR_ICLR, 32'h1);
    bus(0, `LIL_ADR_ISTAT, 0);
    `CHK("status cleared", 1'b0, rd[0])
    bus(1, `LIL_ADR_ACK, 32'h1);
    lamp("ack cleared", 0, 1);
    bus(1, SEL0, 32'h3 | (32'h7 << 25));
    bus(1, CFG0, 32'h11401);
    lil_src_inst.set(32'h8, 0, 0, 1);
    lil_src_inst.set(32'h80, 0, 0, 1);
    lamp("ack source", 0, 1);
    bus(1, CFG0, 32'h11801);
    lil_src_inst.set(32'h8, 0, 0, 1);
    lil_src_inst.set(32'h80, 0, 0, 1);
    lamp("source ignored", 1, 0);
    lil_src_inst.set(0, 1, 0, 1);
    lamp("alarm ack", 0, 1);
    lil_src_inst.set(32'h8, 1, 0, 1);
    for (int c = 0; c < 4; c++) begin
      bus(1, CFG0, 32'h1 | (c << 12));
      repeat (3) @(posedge clk_i);
      nr = 0;
      ng = 0;
      repeat (16) begin
        @(posedge clk_i);
        #1;
        nr += red[0];
        ng += grn[0];
      end
      `CHK("red count", (c == 1) ? 16 : (c == 2) ? 8 : 0, nr)
      `CHK("green count", (c == 0) ? 16 : (c == 3) ? 8 : 0, ng)
    end
    lil_src_inst.set(0, 0, 5'h15, 1);
    lamp("led idle", 0, 1);
    `CHK("relays", 5'h15, rly)
    bus(1, `LIL_ADR_FEN, 32'h1);
    lamp("led still idle", 0, 1);
    `CHK("forced relay", 5'h14, rly)
    `CHK("forced flag", 1'b1, frc)
    bus(0, `LIL_ADR_STAT, 0);
    `CHK("forced status", 1'b1, rd[6])
    bus(1, `LIL_ADR_CTRL, 32'h1);
    lil_src_inst.set(0, 0, 5'h15, 0);
    lamp("led idle too", 0, 1);
    `CHK("disarmed relays", 5'h00, rly)
    `CHK("disarm flag", 1'b1, dis)
    `CHK("supervision", 1'b0, sso)
    stop_test;
  end
endmodule
bind lil_top lil_monitor lil_monitor_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .rly_req_i(rly_req_i), .selfsup_ok_i(selfsup_ok_i),
  .led_red_o(led_red_o), .led_green_o(led_green_o),
  .relay_output_1_state_o(relay_output_1_state_o), .relay_output_2_state_o(relay_output_2_state_o),
  .relay_output_3_state_o(relay_output_3_state_o), .relay_output_4_state_o(relay_output_4_state_o),
  .relay_output_5_state_o(relay_output_5_state_o), .selfsup_o(selfsup_o),
  .disarmed_o(disarmed_o), .outs_forced_o(outs_forced_o));

/* verilog/lil_defs.vh */
// Function
// - active colour while OR of slots true
// - inactive colour while OR result false
// - colour codes green, red, red flash, green flash
// - per-slot inversion before OR, default off
// - latch modes none, latched, ack by alarm
// - ack clears latch only once causes gone
// - ack source honoured only in latched mode
// - one state output per output relay
// - forced flag while any relay forced
// - forced value overrides assigned relay drive
// - disarmed flag; supervision contact never disarmed
`ifndef LIL_DEFS_VH
`define LIL_DEFS_VH

// sizes
`define LIL_NLED 4
`define LIL_NSLOT 5
`define LIL_NREL 5

// register byte offsets
`define LIL_ADR_CTRL 8'h00
`define LIL_ADR_FEN 8'h04
`define LIL_ADR_FVAL 8'h08
`define LIL_ADR_STAT 8'h0C
`define LIL_ADR_ISTAT 8'h10
`define LIL_ADR_ICLR 8'h14
`define LIL_ADR_IEN 8'h18
`define LIL_ADR_ACK 8'h1C
`define LIL_ADR_LBASE 8'h20
`define LIL_LED_STRIDE 8'h08

// led config fields
`define LIL_CFG_USED 0
`define LIL_CFG_INV 5
`define LIL_CFG_LAT 10
`define LIL_CFG_ON 12
`define LIL_CFG_OFF 14
`define LIL_CFG_ACKEN 16
`define LIL_SEL_ACK 25

// reset values
`define LIL_CFG_RST 32'h00001000
`define LIL_SEL_RST 32'h00000000

// colour codes
`define LIL_COL_GREEN 2'h0
`define LIL_COL_RED 2'h1
`define LIL_COL_RFLASH 2'h2
`define LIL_COL_GFLASH 2'h3

// latch modes
`define LIL_LAT_NONE 2'h0
`define LIL_LAT_ACK 2'h1
`define LIL_LAT_ALARM 2'h2

// blink half period
`define LIL_BLINK_MS 250
`define LIL_CLK_KHZ 25000

`endif

/* verilog/lil_led.v */
`timescale 1ns/10ps
`include "lil_defs.vh"

module lil_led (
  input wire clk_i, // system clock
  input wire rst_i, // synchronous reset, high
  input wire [31:0] sig_i, // internal signal sources
  input wire [31:0] sel_i, // slot and ack source indices
  input wire [31:0] cfg_i, // slot, latch and colour settings
  input wire ack_sw_i, // software acknowledge pulse
  input wire alarm_i, // alarm rising pulse
  input wire blink_i, // blink phase
  output reg red_o, // red lamp drive
  output reg green_o, // green lamp drive
  output reg active_o, // shown state, latched or live
  output reg pickup_o // one-cycle pulse on pickup
);

  reg latch; // held pickup
  reg or_now; // live OR of slots
  reg ack_now; // any acknowledge this cycle
  reg [1:0] code; // selected colour code
  wire [1:0] mode; // latch mode
  integer k;

  assign mode = cfg_i[`LIL_CFG_LAT +: 2];

  // OR of up to five slots, unassigned slots read zero then invert
  always @* begin
    or_now = 1'b0;
    for (k = 0; k < `LIL_NSLOT; k = k + 1) begin
      or_now = or_now | ((cfg_i[`LIL_CFG_USED + k] & sig_i[sel_i[5 * k +: 5]])
        ^ cfg_i[`LIL_CFG_INV + k]);
    end
  end

  // ack sources: selected signal only when plainly latched
  always @* begin
    ack_now = ack_sw_i;
    if (mode == `LIL_LAT_ACK) begin
      ack_now = ack_now | (cfg_i[`LIL_CFG_ACKEN] & sig_i[sel_i[`LIL_SEL_ACK +: 5]]);
    end else if (mode == `LIL_LAT_ALARM) begin
      ack_now = ack_now | alarm_i;
    end
  end

  // colour of the shown state
  always @* begin
    if (or_now | latch) begin
      code = cfg_i[`LIL_CFG_ON +: 2];
    end else begin
      code = cfg_i[`LIL_CFG_OFF +: 2];
    end
  end

  // latch, shown state and lamp drive
  always @(posedge clk_i) begin
    if (rst_i) begin
      latch <= 1'b0;
      active_o <= 1'b0;
      pickup_o <= 1'b0;
      red_o <= 1'b0;
      green_o <= 1'b0;
    end else begin
      if (mode == `LIL_LAT_NONE) begin
        latch <= 1'b0;
      end else if (or_now) begin
        latch <= 1'b1;
      end else if (ack_now) begin
        latch <= 1'b0;
      end
      active_o <= or_now | latch;
      pickup_o <= (or_now | latch) & ~active_o;
      // flashing codes go dark on the off half of the blink
      red_o <= (code == `LIL_COL_RED) | ((code == `LIL_COL_RFLASH) & blink_i);
      green_o <= (code == `LIL_COL_GREEN) | ((code == `LIL_COL_GFLASH) & blink_i);
    end
  end

endmodule

/* verilog/lil_top.v */
// Implementation choices: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`include "lil_defs.vh"

module lil_top #(
  parameter [31:0] BLINK_HALF = `LIL_BLINK_MS * `LIL_CLK_KHZ // cycles per blink half
) (
  input wire clk_i, // system clock, 25 MHz
  input wire rst_i, // synchronous reset, high
  // wishbone slave
  input wire wb_cyc_i, // bus cycle
  input wire wb_stb_i, // strobe
  input wire wb_we_i, // write enable
  input wire [7:0] wb_adr_i, // byte address
  input wire [31:0] wb_dat_i, // write data
  input wire [3:0] wb_sel_i, // byte lanes
  output reg [31:0] wb_dat_o, // read data
  output reg wb_ack_o, // acknowledge
  output wire irq_o, // level interrupt
  // signal sources, same clock domain
  input wire [31:0] sig_i, // protection signals
  input wire alarm_i, // general alarm level
  input wire [4:0] rly_req_i, // assigned relay drives
  input wire selfsup_ok_i, // supervision healthy
  // outputs
  output wire [3:0] led_red_o, // red lamps
  output wire [3:0] led_green_o, // green lamps
  output reg relay_output_1_state_o, // relay 1 state
  output reg relay_output_2_state_o, // relay 2 state
  output reg relay_output_3_state_o, // relay 3 state
  output reg relay_output_4_state_o, // relay 4 state
  output reg relay_output_5_state_o, // relay 5 state
  output reg selfsup_o, // supervision contact
  output reg disarmed_o, // relays disarmed flag
  output reg outs_forced_o // outputs forced flag
);

  // byte-lane merge used by the per-led sel and cfg registers
  function [31:0] lil_merge;
    input [31:0] old;
    input [31:0] nv;
    input [3:0] sel;
    integer b;
    begin
      lil_merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          lil_merge[8 * b +: 8] = nv[8 * b +: 8];
        end
      end
    end
  endfunction

  // true when the address falls in the per-led window
  function lil_is_led;
    input [7:0] adr;
    begin
      lil_is_led = (adr >= `LIL_ADR_LBASE) &&
        (adr < (`LIL_ADR_LBASE + `LIL_NLED * `LIL_LED_STRIDE));
    end
  endfunction

  // software registers
  reg disarm; // disarm request
  reg [4:0] force_en; // per relay force enable
  reg [4:0] force_val; // per relay forced value
  reg [4:0] irq_stat; // sticky events
  reg [4:0] irq_en; // event enables
  reg [31:0] led_sel [0:3]; // slot source indices
  reg [31:0] led_cfg [0:3]; // slot and display settings

  // bus decode
  wire req; // live request
  wire wr_fire; // write takes effect
  wire [1:0] led_idx; // led addressed
  wire led_hit; // in led window
  wire [7:0] adr_w; // word-aligned address
  reg [31:0] rd_mux; // read value

  // event logic
  reg [22:0] blink_cnt; // blink divider
  reg blink; // blink phase
  reg alarm_q; // alarm delayed
  wire alarm_rise; // alarm pulse
  reg forced_q; // forced flag delayed
  wire [3:0] sw_ack; // software ack pulses
  wire [4:0] irq_clr; // clear pulses
  wire [3:0] led_act; // shown led states
  wire [3:0] led_pick; // led pickup pulses
  wire [4:0] events; // event vector
  wire [4:0] next_rel; // next relay states
  wire any_forced; // some relay forced
  wire [4:0] rel_state; // relay states as vector

  assign adr_w = {wb_adr_i[7:2], 2'b00};
  assign req = wb_cyc_i & wb_stb_i;
  // writes land on the edge where the master sees ack
  assign wr_fire = req & wb_we_i & wb_ack_o;
  assign led_hit = lil_is_led(adr_w);
  assign led_idx = adr_w[4:3];

  // ack one cycle after request, dropped the cycle after
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  // read multiplexer, unmapped reads zero
  always @* begin
    rd_mux = 32'h00000000;
    if (led_hit) begin
      if (adr_w[2]) begin
        rd_mux = led_cfg[led_idx];
      end else begin
        rd_mux = led_sel[led_idx];
      end
    end else begin
      case (adr_w)
        `LIL_ADR_CTRL: rd_mux = {31'h00000000, disarm};
        `LIL_ADR_FEN: rd_mux = {27'h0000000, force_en};
        `LIL_ADR_FVAL: rd_mux = {27'h0000000, force_val};
        // live state word, relays, flags and leds
        `LIL_ADR_STAT: rd_mux = {20'h00000, led_act, 1'b0, outs_forced_o,
          disarmed_o, rel_state};
        `LIL_ADR_ISTAT: rd_mux = {27'h0000000, irq_stat};
        `LIL_ADR_IEN: rd_mux = {27'h0000000, irq_en};
        default: rd_mux = 32'h00000000; // write-only or unmapped
      endcase
    end
  end

  // read data captured as ack rises, stands for the ack cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (req & ~wb_ack_o) begin
      wb_dat_o <= rd_mux;
    end
  end

  // global control registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      disarm <= 1'b0;
      force_en <= 5'h00;
      force_val <= 5'h00;
      irq_en <= 5'h00;
    end else if (wr_fire) begin
      case (adr_w)
        // these fields all sit in byte lane 0, so only that lane matters
        `LIL_ADR_CTRL: disarm <= wb_sel_i[0] ? wb_dat_i[0] : disarm;
        `LIL_ADR_FEN: force_en <= wb_sel_i[0] ? wb_dat_i[4:0] : force_en;
        `LIL_ADR_FVAL: force_val <= wb_sel_i[0] ? wb_dat_i[4:0] : force_val;
        `LIL_ADR_IEN: irq_en <= wb_sel_i[0] ? wb_dat_i[4:0] : irq_en;
        default: disarm <= disarm; // other addresses leave these alone
      endcase
    end
  end

  // per-led setting registers, indexed by led number
  integer i;
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (i = 0; i < `LIL_NLED; i = i + 1) begin
        led_sel[i] <= `LIL_SEL_RST;
        led_cfg[i] <= `LIL_CFG_RST;
      end
    end else if (wr_fire & led_hit) begin
      if (adr_w[2]) begin
        led_cfg[led_idx] <= lil_merge(led_cfg[led_idx], wb_dat_i, wb_sel_i);
      end else begin
        led_sel[led_idx] <= lil_merge(led_sel[led_idx], wb_dat_i, wb_sel_i);
      end
    end
  end

  // pulses from write-only registers, lane 0 only
  assign sw_ack = (wr_fire & (adr_w == `LIL_ADR_ACK) & wb_sel_i[0]) ?
    wb_dat_i[3:0] : 4'h0;
  assign irq_clr = (wr_fire & (adr_w == `LIL_ADR_ICLR) & wb_sel_i[0]) ?
    wb_dat_i[4:0] : 5'h00;

  // blink divider; the half period is long, so it is a parameter
  always @(posedge clk_i) begin
    if (rst_i) begin
      blink_cnt <= 23'h000000;
      blink <= 1'b0;
    end else if (blink_cnt >= BLINK_HALF[22:0] - 23'h000001) begin
      blink_cnt <= 23'h000000;
      blink <= ~blink;
    end else begin
      blink_cnt <= blink_cnt + 23'h000001;
    end
  end

  // alarm edge for the ack-by-alarm mode
  always @(posedge clk_i) begin
    if (rst_i) begin
      alarm_q <= 1'b0;
    end else begin
      alarm_q <= alarm_i;
    end
  end
  assign alarm_rise = alarm_i & ~alarm_q;

  // one indicator channel per led
  genvar g;
  generate
    for (g = 0; g < `LIL_NLED; g = g + 1) begin : gen_led
      lil_led u_led (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sig_i(sig_i),
        .sel_i(led_sel[g]),
        .cfg_i(led_cfg[g]),
        .ack_sw_i(sw_ack[g]),
        .alarm_i(alarm_rise),
        .blink_i(blink),
        .red_o(led_red_o[g]),
        .green_o(led_green_o[g]),
        .active_o(led_act[g]),
        .pickup_o(led_pick[g])
      );
    end
  endgenerate

  // forced value wins over the assigned drive; disarm wins over both
  assign next_rel = disarm ? 5'h00 :
    ((force_en & force_val) | (~force_en & rly_req_i));
  assign any_forced = |force_en;

  // relay states, flags and supervision contact
  always @(posedge clk_i) begin
    if (rst_i) begin
      relay_output_1_state_o <= 1'b0;
      relay_output_2_state_o <= 1'b0;
      relay_output_3_state_o <= 1'b0;
      relay_output_4_state_o <= 1'b0;
      relay_output_5_state_o <= 1'b0;
      selfsup_o <= 1'b0;
      disarmed_o <= 1'b0;
      outs_forced_o <= 1'b0;
      forced_q <= 1'b0;
    end else begin
      relay_output_1_state_o <= next_rel[0];
      relay_output_2_state_o <= next_rel[1];
      relay_output_3_state_o <= next_rel[2];
      relay_output_4_state_o <= next_rel[3];
      relay_output_5_state_o <= next_rel[4];
      // supervision contact ignores disarm on purpose
      selfsup_o <= selfsup_ok_i;
      disarmed_o <= disarm;
      outs_forced_o <= any_forced;
      forced_q <= any_forced;
    end
  end

  assign rel_state = {relay_output_5_state_o, relay_output_4_state_o,
    relay_output_3_state_o, relay_output_2_state_o, relay_output_1_state_o};

  // events: led pickups and forced flag rising
  assign events = {any_forced & ~forced_q, led_pick};

  // sticky status; a new event wins over a clear in the same cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= 5'h00;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | events;
    end
  end

  // interrupt high while any enabled status bit is set
  assign irq_o = |(irq_stat & irq_en);

endmodule
